// ### pcs_regs.vh
// Register map, field positions and timing constants for the pulse sequencer
`ifndef PCS_REGS_VH
`define PCS_REGS_VH

// Register byte offsets
`define PCS_ADDR_CTRL 8'h00
`define PCS_ADDR_STATUS 8'h04
`define PCS_ADDR_INT_STAT 8'h08
`define PCS_ADDR_INT_MASK 8'h0c
`define PCS_ADDR_W 8

// Control register fields
`define PCS_CTRL_CONTACT 0
`define PCS_CTRL_REMOTE 1
`define PCS_CTRL_RESET 2
`define PCS_CTRL_W 2
`define PCS_CTRL_RST_VAL 2'h0

// Status register fields
`define PCS_ST_HV_GATE 0
`define PCS_ST_CHG_EN 1
`define PCS_ST_FAULT 2
`define PCS_ST_TIMEOUT 3
`define PCS_ST_LOAD 4
`define PCS_ST_INHIBIT 5
`define PCS_ST_LOCKOUT 6
`define PCS_ST_RELAY_LO 8
`define PCS_ST_RELAY_HI 11

// Interrupt status and mask fields
`define PCS_IRQ_FIRE 0
`define PCS_IRQ_TIMEOUT 1
`define PCS_IRQ_LOAD 2
`define PCS_IRQ_SELECT 3
`define PCS_IRQ_FAULT 4
`define PCS_IRQ_W 5
`define PCS_IRQ_RST_VAL 5'h00

// Number of switchable storage capacitors
`define PCS_NCAP 4
// Synchronised input count: 3 keys, 4 buttons, 2 load, 4 selectors
`define PCS_NSYNC 13

// Clock rate and times in milliseconds
`define PCS_CLK_KHZ 100000
`define PCS_LOCKOUT_MS 150
`define PCS_FIRE_MS 1
`define PCS_TIMEOUT_MS 20250
`define PCS_INHIBIT_MS 10
`define PCS_LOAD_CLR_MS 10000
`define PCS_STAGGER_MS 500
`define PCS_CHG_ON_MS 3000

// AHB encodings
`define PCS_HTRANS_NONSEQ 2'h2
`define PCS_HRESP_OKAY 1'h0

`endif

// ### pcs_sync.v
// Two-flop synchroniser bank for asynchronous panel inputs
`timescale 1ns/10ps
`default_nettype none
module pcs_sync #(
    parameter W = 1
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta;
            reg stab;
            // First stage feeds only the second stage
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta <= 1'b0;
                    stab <= 1'b0;
                end else if (i_ce) begin
                    meta <= i_d[g];
                    stab <= meta;
                end
            end
            assign o_q[g] = stab;
        end
    endgenerate
endmodule
`default_nettype wire

// ### pcs_timer.v
// Retriggerable one-shot down counter with busy level and done pulse
`timescale 1ns/10ps
`default_nettype none
module pcs_timer (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire i_start,
    input wire [31:0] i_cyc,
    output reg o_busy,
    output reg o_done
);
    reg [31:0] cnt;

    // Busy for exactly i_cyc cycles, then one done cycle
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 32'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            if (i_start) begin
                cnt <= i_cyc;
                o_busy <= 1'b1;
                o_done <= 1'b0;
            end else if (o_busy && cnt <= 32'h1) begin
                o_busy <= 1'b0;
                o_done <= 1'b1;
            end else begin
                cnt <= o_busy ? cnt - 32'h1 : cnt;
                o_done <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ### pcs_sequencer.v
// Pulse charger sequencer: keying, firing, faults, capacitor switching
`timescale 1ns/10ps
`default_nettype none
`include "pcs_regs.vh"
module pcs_sequencer #(
    parameter [31:0] P_LOCKOUT_CYC = `PCS_LOCKOUT_MS * `PCS_CLK_KHZ,
    parameter [31:0] P_FIRE_CYC = `PCS_FIRE_MS * `PCS_CLK_KHZ,
    parameter [31:0] P_TIMEOUT_CYC = `PCS_TIMEOUT_MS * `PCS_CLK_KHZ,
    parameter [31:0] P_INHIBIT_CYC = `PCS_INHIBIT_MS * `PCS_CLK_KHZ,
    parameter [31:0] P_LOAD_CLR_CYC = `PCS_LOAD_CLR_MS * `PCS_CLK_KHZ,
    parameter [31:0] P_STAGGER_CYC = `PCS_STAGGER_MS * `PCS_CLK_KHZ,
    parameter [31:0] P_CHG_ON_CYC = `PCS_CHG_ON_MS * `PCS_CLK_KHZ
) (
    input wire i_clk,
    input wire i_nrst,
    input wire i_ce,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output reg [31:0] o_hrdata,
    output reg o_hreadyout,
    output reg o_hresp,
    input wire i_front_key,
    input wire i_remote_key,
    input wire i_manual_key,
    input wire i_hv_on_front,
    input wire i_hv_on_remote,
    input wire i_hv_off_front,
    input wire i_hv_off_remote,
    input wire i_load_overcurrent,
    input wire i_load_open,
    input wire [3:0] i_cap_sel_n,
    output reg o_fire_pulse,
    output reg o_charger_inhibit,
    output reg o_charger_enable_relay,
    output reg [3:0] o_capacitor_relay_drive,
    output reg o_fault_led,
    output reg o_timeout_led,
    output reg o_load_fault_led,
    output reg o_remote_hv_led,
    output reg o_remote_key_led,
    output reg o_irq
);
    // Rising edge of a synchronised level, used for every button and key
    function pcs_rise;
        input cur;
        input prev;
        begin
            pcs_rise = cur & ~prev;
        end
    endfunction

    reg [1:0] rst_sync;
    reg [1:0] sel_warm;
    wire rst_n;
    wire [12:0] sin;
    reg [12:0] sin_d;
    reg [`PCS_CTRL_W-1:0] ctrl;
    reg [`PCS_IRQ_W-1:0] int_stat;
    reg [`PCS_IRQ_W-1:0] int_mask;
    reg fault, timeout_flag, load_flag, hv_latch;
    reg sel_valid, wr_pend, soft_reset;
    reg [31:0] elapsed;
    reg [`PCS_ADDR_W-1:0] wr_addr;
    wire hv_gate, key_front, key_req, lock_busy, lock_done, fire_busy;
    wire inh_busy, to_done, load_done, load_event, sel_change;
    wire hv_on_req, hv_off_req, fire_start, chg_due, bus_go;
    wire [3:0] relay_due;
    wire [`PCS_ADDR_W-1:0] addr;
    wire [`PCS_IRQ_W-1:0] events;
    wire [`PCS_IRQ_W-1:0] int_clr;
    wire [31:0] status_word;

    // Reset released through two flops
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // All panel inputs pass a two-flop synchroniser
    pcs_sync #(
        .W(`PCS_NSYNC)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_d({i_cap_sel_n, i_load_open, i_load_overcurrent,
              i_hv_off_remote, i_hv_off_front, i_hv_on_remote,
              i_hv_on_front, i_manual_key, i_remote_key, i_front_key}),
        .o_q(sin)
    );

    // Previous samples for edge detection
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sin_d <= 13'h0000;
            sel_warm <= 2'h0;
            sel_valid <= 1'b0;
        end else if (i_ce) begin
            sin_d <= sin;
            sel_warm <= {sel_warm[0], 1'b1};
            sel_valid <= sel_warm[1];
        end
    end

    // Contact mode keys the front input on the closure (line pulled low)
    assign key_front = ctrl[`PCS_CTRL_CONTACT] ?
        pcs_rise(~sin[0], ~sin_d[0]) : pcs_rise(sin[0], sin_d[0]);
    assign key_req = key_front | pcs_rise(sin[1], sin_d[1]) |
        pcs_rise(sin[2], sin_d[2]);

    // Only the selected location may switch HV on; either may switch off
    assign hv_on_req = ctrl[`PCS_CTRL_REMOTE] ?
        pcs_rise(sin[4], sin_d[4]) : pcs_rise(sin[3], sin_d[3]);
    assign hv_off_req = pcs_rise(sin[5], sin_d[5]) |
        pcs_rise(sin[6], sin_d[6]);

    assign load_event = pcs_rise(sin[7] | sin[8], sin_d[7] | sin_d[8]);
    // Wait out synchroniser fill; its reset zeros are no selector change
    assign sel_change = sel_valid && (sin[12:9] != sin_d[12:9]);

    // Keys seen during lockout are dropped, not queued
    pcs_timer u_key_lockout_timer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_start(key_req & ~lock_busy),
        .i_cyc(P_LOCKOUT_CYC),
        .o_busy(lock_busy),
        .o_done(lock_done)
    );

    // Firing follows the lockout, blocked by a latched fault
    assign fire_start = lock_done & ~fault;

    pcs_timer u_fire_pulse_timer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_start(fire_start),
        .i_cyc(P_FIRE_CYC),
        .o_busy(fire_busy),
        .o_done()
    );

    // Inhibit starts with the shot and outlasts it
    pcs_timer u_charger_inhibit_timer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_start(fire_start),
        .i_cyc(P_INHIBIT_CYC),
        .o_busy(inh_busy),
        .o_done()
    );

    // Reloaded by every key and held while HV is off
    pcs_timer u_no_key_timeout (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_start(key_req | ~hv_gate),
        .i_cyc(P_TIMEOUT_CYC),
        .o_busy(),
        .o_done(to_done)
    );

    // Load fault holds for a fixed time, renewed by a new event
    pcs_timer u_load_clear_timer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_start(load_event),
        .i_cyc(P_LOAD_CLR_CYC),
        .o_busy(),
        .o_done(load_done)
    );

    // Fault, timeout and load flags; setting wins over clearing
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault <= 1'b0;
            timeout_flag <= 1'b0;
            load_flag <= 1'b0;
        end else if (i_ce) begin
            fault <= (to_done | sel_change | load_event) |
                (fault & ~(hv_off_req | soft_reset));
            timeout_flag <= to_done |
                (timeout_flag & ~(hv_off_req | soft_reset));
            load_flag <= load_event | (load_flag & ~load_done);
        end
    end

    // HV on latch, dropped by off, fault or reset
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            hv_latch <= 1'b0;
        end else if (i_ce) begin
            if (hv_off_req | fault | soft_reset) begin
                hv_latch <= 1'b0;
            end else if (hv_on_req) begin
                hv_latch <= 1'b1;
            end
        end
    end
    assign hv_gate = hv_latch & ~fault;

    // Time since HV enable, saturating once the charger is due
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed <= 32'h0;
        end else if (i_ce) begin
            if (!hv_gate) begin
                elapsed <= 32'h0;
            end else if (!chg_due) begin
                elapsed <= elapsed + 32'h1;
            end
        end
    end
    assign chg_due = (elapsed >= P_CHG_ON_CYC);

    // Capacitor n closes at (n+1) stagger steps, all before 3 s
    genvar c;
    generate
        for (c = 0; c < `PCS_NCAP; c = c + 1) begin : g_cap
            localparam [31:0] LP_DUE = P_STAGGER_CYC * (c + 1);
            assign relay_due[c] = hv_gate & ~sin[9 + c] &
                (elapsed >= LP_DUE);
        end
    endgenerate

    // All block outputs are registered
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_fire_pulse <= 1'b0;
            o_charger_inhibit <= 1'b0;
            o_charger_enable_relay <= 1'b0;
            o_capacitor_relay_drive <= 4'h0;
            o_fault_led <= 1'b0;
            o_timeout_led <= 1'b0;
            o_load_fault_led <= 1'b0;
            o_remote_hv_led <= 1'b0;
            o_remote_key_led <= 1'b0;
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_fire_pulse <= fire_busy;
            o_charger_inhibit <= inh_busy;
            o_charger_enable_relay <= hv_gate & chg_due;
            o_capacitor_relay_drive <= relay_due;
            o_fault_led <= fault | load_flag;
            o_timeout_led <= timeout_flag;
            o_load_fault_led <= load_flag;
            o_remote_hv_led <= hv_gate;
            o_remote_key_led <= lock_busy | fire_busy;
            o_irq <= |(int_stat & int_mask);
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    assign bus_go = i_hsel & i_hready & (i_htrans == `PCS_HTRANS_NONSEQ);
    assign addr = i_haddr[`PCS_ADDR_W-1:0];
    assign events = {(to_done | sel_change | load_event) & ~fault,
        sel_change, load_event, to_done, fire_start};
    // Reading the interrupt status clears exactly what it returned
    assign int_clr = (bus_go && !i_hwrite && addr == `PCS_ADDR_INT_STAT) ?
        int_stat : {`PCS_IRQ_W{1'b0}};
    assign status_word = {20'h00000, o_capacitor_relay_drive, 1'b0,
        lock_busy, inh_busy, load_flag, timeout_flag, fault,
        o_charger_enable_relay, hv_gate};

    // Address phase captures, data phase writes
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_hrdata <= 32'h0;
            o_hreadyout <= 1'b1;
            o_hresp <= `PCS_HRESP_OKAY;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            ctrl <= `PCS_CTRL_RST_VAL;
            int_mask <= `PCS_IRQ_RST_VAL;
            int_stat <= `PCS_IRQ_RST_VAL;
            soft_reset <= 1'b0;
        end else if (i_ce) begin
            o_hreadyout <= 1'b1;
            o_hresp <= `PCS_HRESP_OKAY;
            wr_pend <= bus_go & i_hwrite;
            wr_addr <= addr;
            soft_reset <= 1'b0;
            // New events win over a read clear in the same cycle
            int_stat <= (int_stat & ~int_clr) | events;
            if (bus_go && !i_hwrite) begin
                case (addr)
                    `PCS_ADDR_CTRL: o_hrdata <= {30'h0, ctrl};
                    `PCS_ADDR_STATUS: o_hrdata <= status_word;
                    `PCS_ADDR_INT_STAT: o_hrdata <= {27'h0, int_stat};
                    `PCS_ADDR_INT_MASK: o_hrdata <= {27'h0, int_mask};
                    default: o_hrdata <= 32'h0;
                endcase
            end
            if (wr_pend) begin
                case (wr_addr)
                    `PCS_ADDR_CTRL: begin
                        ctrl <= i_hwdata[`PCS_CTRL_W-1:0];
                        soft_reset <= i_hwdata[`PCS_CTRL_RESET];
                    end
                    `PCS_ADDR_INT_MASK: int_mask <= i_hwdata[`PCS_IRQ_W-1:0];
                    default: soft_reset <= 1'b0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### pcs_props.sv
// Port checker for the pulse charger sequencer
`timescale 1ns/10ps
`default_nettype none
module pcs_props #(
    parameter [31:0] P_LOCKOUT_CYC = 20,
    parameter [31:0] P_FIRE_CYC = 4,
    parameter [31:0] P_INHIBIT_CYC = 10,
    parameter [31:0] P_LOAD_CLR_CYC = 50,
    parameter [31:0] P_STAGGER_CYC = 8,
    parameter [31:0] P_CHG_ON_CYC = 40
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic o_fire_pulse,
    input wire logic o_charger_inhibit,
    input wire logic o_charger_enable_relay,
    input wire logic [3:0] o_capacitor_relay_drive,
    input wire logic o_fault_led,
    input wire logic o_timeout_led,
    input wire logic o_load_fault_led,
    input wire logic o_remote_hv_led,
    input wire logic o_remote_key_led
);
    logic [31:0] fire_n, inh_n, rise_n, hv_n, ld_n;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);
    // Run lengths of level outputs, and cycles since the last fire rise; 32 bits never wrap in a run
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fire_n <= 32'h0;
            inh_n <= 32'h0;
            rise_n <= 32'h0;
            hv_n <= 32'h0;
            ld_n <= 32'h0;
        end else begin
            fire_n <= o_fire_pulse ? fire_n + 32'h1 : 32'h0;
            inh_n <= o_charger_inhibit ? inh_n + 32'h1 : 32'h0;
            rise_n <= (o_fire_pulse && fire_n == 32'h0) ? 32'h1
                : rise_n + 32'h1;
            hv_n <= o_remote_hv_led ? hv_n + 32'h1 : 32'h0;
            ld_n <= o_load_fault_led ? ld_n + 32'h1 : 32'h0;
        end
    end
    sequence s_fire_go;
        $rose(o_fire_pulse);
    endsequence
    sequence s_inh_go;
        $rose(o_charger_inhibit);
    endsequence
    property p_fire_width;
        $fell(o_fire_pulse) |-> fire_n == P_FIRE_CYC;
    endproperty
    a_fire_width: assert property (p_fire_width)
        else $error("fire pulse width wrong");
    property p_inh_start;
        s_fire_go |-> s_inh_go;
    endproperty
    a_inh_start: assert property (p_inh_start)
        else $error("inhibit not started with fire");
    property p_inh_width;
        $fell(o_charger_inhibit) |-> inh_n == P_INHIBIT_CYC;
    endproperty
    a_inh_width: assert property (p_inh_width)
        else $error("inhibit width wrong");
    property p_rate;
        s_fire_go |-> rise_n >= P_LOCKOUT_CYC;
    endproperty
    a_rate: assert property (p_rate)
        else $error("fires closer than lockout");
    property p_key_led;
        o_fire_pulse |-> o_remote_key_led;
    endproperty
    a_key_led: assert property (p_key_led)
        else $error("key indicator off during fire");
    property p_relay_gate;
        |o_capacitor_relay_drive |-> o_remote_hv_led || $past(o_remote_hv_led);
    endproperty
    a_relay_gate: assert property (p_relay_gate)
        else $error("relay closed without hv gate");
    property p_relay_delay;
        $rose(o_capacitor_relay_drive[0]) |->
            hv_n >= P_STAGGER_CYC - 32'h2 && hv_n <= P_STAGGER_CYC + 32'h2;
    endproperty
    a_relay_delay: assert property (p_relay_delay)
        else $error("first relay delay wrong");
    property p_chg_delay;
        $rose(o_charger_enable_relay) |->
            hv_n >= P_CHG_ON_CYC - 32'h2 && hv_n <= P_CHG_ON_CYC + 32'h2;
    endproperty
    a_chg_delay: assert property (p_chg_delay)
        else $error("charger enable delay wrong");
    property p_chg_order;
        $rose(o_charger_enable_relay) |->
            o_remote_hv_led && $stable(o_capacitor_relay_drive);
    endproperty
    a_chg_order: assert property (p_chg_order)
        else $error("relays moved at charger enable");
    property p_timeout_drop;
        $rose(o_timeout_led) |-> ##[0:2] (o_fault_led && !o_remote_hv_led);
    endproperty
    a_timeout_drop: assert property (p_timeout_drop)
        else $error("timeout did not drop hv");
    property p_load_clear;
        o_load_fault_led |-> ld_n <= P_LOAD_CLR_CYC + 32'h4;
    endproperty
    a_load_clear: assert property (p_load_clear)
        else $error("load flag did not self clear");
endmodule
bind pcs_sequencer pcs_props #(.P_LOCKOUT_CYC(P_LOCKOUT_CYC),
    .P_FIRE_CYC(P_FIRE_CYC), .P_INHIBIT_CYC(P_INHIBIT_CYC),
    .P_LOAD_CLR_CYC(P_LOAD_CLR_CYC), .P_STAGGER_CYC(P_STAGGER_CYC),
    .P_CHG_ON_CYC(P_CHG_ON_CYC)) u_props (.*);
`default_nettype wire

// ### pcs_panel_model.sv
// Operator panel and key source model
`timescale 1ns/10ps
`default_nettype none
module pcs_panel_model (
    input wire logic i_clk,
    output var logic [8:0] o_lines,
    output var logic [3:0] o_sel_n
);
    // Lines idle low, selectors parked on no capacitor
    initial begin
        o_lines = 9'h000;
        o_sel_n = 4'hf;
    end
    // Toggle a line and back; len picks a prompt or slow press
    task automatic pulse(input int i, input int len);
        @(posedge i_clk);
        o_lines <= o_lines ^ (9'h001 << i);
        repeat (len) @(posedge i_clk);
        o_lines <= o_lines ^ (9'h001 << i);
    endtask
    // Active-low selector code, 0 picks a capacitor
    task automatic set_sel(input logic [3:0] v);
        @(posedge i_clk);
        o_sel_n <= v;
    endtask
endmodule
`default_nettype wire

// ### pcs_sequencer_tb.sv
// Self-checking bench for the pulse charger sequencer
`timescale 1ns/10ps
`default_nettype none
module pcs_sequencer_tb;
    localparam int LK = 20, FR = 4, TO = 300, CH = 40, LC = 50;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_hsel = 1'b0;
    logic i_hwrite = 1'b0;
    logic [1:0] i_htrans = 2'h0;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_haddr = 32'h0;
    logic [31:0] i_hwdata = 32'h0;
    wire [31:0] o_hrdata;
    wire o_hreadyout, o_hresp, o_fire_pulse, o_charger_inhibit, o_irq;
    wire o_charger_enable_relay, o_fault_led, o_timeout_led;
    wire o_load_fault_led, o_remote_hv_led, o_remote_key_led;
    wire [3:0] o_capacitor_relay_drive, sel_n;
    wire [8:0] ln;
    logic [31:0] q[$];
    logic [31:0] r;
    logic [3:0] s0;
    int mismatches = 0, checks = 0, nrd = 0, nseen = 0, seed = 86;
    pcs_panel_model pm (.i_clk(i_clk), .o_lines(ln), .o_sel_n(sel_n));
    // Short counts keep the run brief; expectations use the same values
    pcs_sequencer #(.P_LOCKOUT_CYC(LK), .P_FIRE_CYC(FR),
        .P_TIMEOUT_CYC(TO), .P_INHIBIT_CYC(10), .P_LOAD_CLR_CYC(LC),
        .P_STAGGER_CYC(8), .P_CHG_ON_CYC(CH)) DUT (.*, .i_ce(1'b1),
        .i_hready(o_hreadyout), .i_front_key(ln[0]), .i_remote_key(ln[1]),
        .i_manual_key(ln[2]), .i_hv_on_front(ln[3]), .i_hv_on_remote(ln[4]),
        .i_hv_off_front(ln[5]), .i_hv_off_remote(ln[6]),
        .i_load_overcurrent(ln[7]), .i_load_open(ln[8]),
        .i_cap_sel_n(sel_n));
    always #5 i_clk = ~i_clk;
    task automatic end_sim;
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    function automatic logic sg(input int id);
        case (id)
            0: return o_hreadyout;
            1: return o_fire_pulse;
            2: return o_charger_enable_relay;
            3: return o_timeout_led;
            4: return o_load_fault_led;
            6: return o_fault_led;
            default: return o_remote_hv_led;
        endcase
    endfunction
    // Bounded wait, sampled at falling edges where outputs have settled
    task automatic wt(input int id, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
            if (n > lim) begin
                mismatches++;
                end_sim();
            end
        end while (sg(id) !== v);
    endtask
    task automatic quiet(input int n);
        logic [31:0] c;
        c = 32'h0;
        repeat (n) begin
            @(negedge i_clk);
            c = c + {31'h0, o_fire_pulse};
        end
        chk(c, 32'h0);
    endtask
    // Single word transfer; address phase held until hready is seen
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_hwrite <= w;
        i_haddr <= {24'h0, a};
        wt(0, 1'b1, 20);
        @(posedge i_clk);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        wt(0, 1'b1, 20);
        @(posedge i_clk);
        if (!w)
            nrd++;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask
    // Oldest note is matched to each completed read
    always @(negedge i_clk) begin
        if (nseen != nrd) begin
            nseen++;
            chk(o_hrdata, q.pop_front());
            chk(o_hresp, 32'h0);
        end
    end
    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end
    initial begin
        r = $random(seed);
        s0 = {r[3:1], 1'b0};
        pm.set_sel(s0);
        repeat (7) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (6) @(posedge i_clk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h10, 32'h0);
        ahb(1'b1, 8'h0c, 32'h1f);
        rd(8'h0c, 32'h1f);
        // Local hv on: staggered relays, then charger
        pm.pulse(3, 3);
        wt(2, 1'b1, CH + 20);
        rd(8'h04, {20'h0, ~s0, 8'h03});
        @(negedge i_clk);
        chk(o_irq, 1'b0);
        // Each source fires once; a second key inside lockout is lost
        for (int i = 0; i < 3; i++) begin
            pm.pulse(i, 2);
            pm.pulse((i + 1) % 3, 2);
            wt(1, 1'b1, LK + 20);
            chk(o_charger_inhibit, 1'b1);
            chk(o_remote_key_led, 1'b1);
            wt(1, 1'b0, FR + 4);
            quiet(LK + 10);
        end
        chk(o_irq, 1'b1);
        rd(8'h08, 32'h01);
        rd(8'h08, 32'h00);
        ahb(1'b1, 8'h00, 32'h1);
        pm.pulse(0, 3);
        wt(1, 1'b1, LK + 20);
        ahb(1'b1, 8'h00, 32'h2);
        rd(8'h08, 32'h01);
        // Remote selected: front on ignored, either off obeyed
        pm.pulse(6, 3);
        wt(5, 1'b0, 20);
        pm.pulse(3, 3);
        repeat (20) @(negedge i_clk);
        chk(o_remote_hv_led, 1'b0);
        pm.pulse(4, 3);
        wt(5, 1'b1, 20);
        pm.pulse(5, 3);
        wt(5, 1'b0, 20);
        ahb(1'b1, 8'h00, 32'h0);
        // No keys: timeout latches fault, keys then blocked
        pm.pulse(3, 3);
        wt(3, 1'b1, TO + 100);
        chk(o_fault_led, 1'b1);
        wt(5, 1'b0, 4);
        chk(o_capacitor_relay_drive, 4'h0);
        chk(o_charger_enable_relay, 1'b0);
        pm.pulse(2, 3);
        quiet(LK + 30);
        rd(8'h08, 32'h12);
        pm.pulse(5, 3);
        wt(6, 1'b0, 10);
        // Overcurrent then open load
        for (int i = 7; i < 9; i++) begin
            pm.pulse(3, 3);
            wt(5, 1'b1, 20);
            pm.pulse(i, 3);
            wt(4, 1'b1, 20);
            wt(5, 1'b0, 10);
            wt(4, 1'b0, LC + 20);
            rd(8'h08, 32'h14);
            pm.pulse(5, 3);
        end
        pm.pulse(3, 3);
        wt(2, 1'b1, CH + 20);
        pm.set_sel(s0 ^ 4'h2);
        wt(5, 1'b0, 20);
        chk(o_charger_enable_relay, 1'b0);
        rd(8'h08, 32'h18);
        // Soft reset clears the fault, then drops a running HV
        ahb(1'b1, 8'h00, 32'h4);
        wt(6, 1'b0, 10);
        pm.pulse(3, 3);
        wt(5, 1'b1, 20);
        ahb(1'b1, 8'h00, 32'h4);
        wt(5, 1'b0, 10);
        chk(o_capacitor_relay_drive, 4'h0);
        repeat (2) @(negedge i_clk);
        end_sim();
    end
endmodule
`default_nettype wire
